// ### hdl/counter_position_period_measure.v
`timescale 1ns/1ps
`include "ctr_pos_regs.vh"
// Position and period measurement counter on the system timebase.
module counter_position_period_measure (
    input wire i_clk_sys,
    input wire i_reset,
    input wire i_arm,
    input wire i_disarm,
    input wire [`MODE_W-1:0] i_mode,
    input wire i_gate_falling,
    input wire i_source_falling,
    input wire [1:0] i_reload_phase,
    input wire i_reload_enable,
    input wire [`CNT_W-1:0] i_reload_value,
    input wire i_sample_enable,
    input wire i_enc_a,
    input wire i_enc_b,
    input wire i_enc_index,
    input wire i_gate,
    input wire i_source,
    input wire i_read_req,
    input wire i_dma_ready,
    output reg o_armed,
    output reg [`CNT_W-1:0] o_count,
    output reg o_read_valid,
    output reg [`CNT_W-1:0] o_read_data,
    output reg o_period_valid,
    output reg [`CNT_W-1:0] o_period,
    output reg [`CNT_W-1:0] o_dma_data,
    output reg o_dma_valid,
    output reg o_overrun
);
    // Two-stage synchronisers for the five outside pins.
    reg [4:0] sync1_r;
    reg [4:0] sync2_r;
    reg [4:0] prev_r; // Previous synchronised levels for edge detection.
    wire a_now = sync2_r[4];
    wire b_now = sync2_r[3];
    wire z_now = sync2_r[2];
    wire g_now = sync2_r[1];
    wire s_now = sync2_r[0];
    wire a_old = prev_r[4];
    wire b_old = prev_r[3];
    wire g_old = prev_r[1];
    wire s_old = prev_r[0];

    reg arm_r; // Armed state.
    reg edges_ok_r; // Previous levels valid; avoids a false edge at arm.
    reg [`CNT_W-1:0] count_r; // Position or period running count.
    reg [`CNT_W-1:0] count_nxt;
    reg period_open_r; // First gate edge seen, interval running.
    reg [`CNT_W-1:0] fifo_din_r; // Capture word toward the FIFO.
    reg fifo_push_r; // Capture strobe.
    wire fifo_in_ready;
    wire [`CNT_W-1:0] fifo_dout;
    wire fifo_out_valid;
    wire dma_pop;

    // Active-edge test for a chosen polarity, used for gate and source.
    function edge_hit;
        input now_lvl;
        input old_lvl;
        input falling;
        begin
            edge_hit = falling ? (old_lvl && !now_lvl) : (!old_lvl && now_lvl);
        end
    endfunction

    wire a_rise = !a_old && a_now;
    wire a_fall = a_old && !a_now;
    wire b_rise = !b_old && b_now;
    wire b_fall = b_old && !b_now;
    wire gate_edge = edges_ok_r && edge_hit(g_now, g_old, i_gate_falling);
    wire src_edge = edges_ok_r && edge_hit(s_now, s_old, i_source_falling);
    wire is_period = (i_mode == `MODE_PERIOD);
    // Reload phase: bit1 is the required A level, bit0 the B level.
    wire phase_true = (a_now == i_reload_phase[`PHASE_A_BIT]) &&
        (b_now == i_reload_phase[`PHASE_B_BIT]);

    // Synchronise every pin before any logic reads it.
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            prev_r <= 5'h00;
        end else begin
            sync1_r <= {i_enc_a, i_enc_b, i_enc_index, i_gate, i_source};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // Decode one step of position change; unknown modes hold the count but for the index reload.
    reg signed [1:0] step;
    always @* begin
        step = 2'sd0;
        case (i_mode)
            `MODE_SINGLE_EDGE_QUADRATURE: begin
                if (a_rise && !b_now) begin
                    step = 2'sd1;
                end else if (a_fall && !b_now) begin
                    step = -2'sd1;
                end
            end
            `MODE_DOUBLE_EDGE_QUADRATURE: begin
                // A leads B when A's new level differs from B.
                if (a_rise || a_fall) begin
                    step = (a_now != b_now) ? 2'sd1 : -2'sd1;
                end
            end
            `MODE_QUADRUPLE_EDGE_QUADRATURE: begin
                if ((a_rise || a_fall) && !(b_rise || b_fall)) begin
                    step = (a_now != b_now) ? 2'sd1 : -2'sd1;
                end else if ((b_rise || b_fall) && !(a_rise || a_fall)) begin
                    step = (a_now == b_now) ? 2'sd1 : -2'sd1;
                end
            end
            `MODE_TWO_PULSE: begin
                if (a_rise && !b_rise) begin
                    step = 2'sd1;
                end else if (b_rise && !a_rise) begin
                    step = -2'sd1;
                end
            end
            default: begin
                step = 2'sd0;
            end
        endcase
    end

    // Next count: a decoded step always wins over the index reload. On
    // entry into the reload phase the step lands this cycle and the
    // reload, deferred one cycle by the phase/index pair, lands next,
    // one timebase period after the step. On the way out of the phase the
    // step is added to the reloaded value, so no edge is lost even when
    // the index stays high past the phase.
    // The reload is level driven: while the index stays high in the
    // phase the count is held at the reload value every cycle.
    reg reload_pend_r; // Phase true with index high, seen last cycle.
    always @* begin
        count_nxt = count_r;
        if (edges_ok_r && !is_period && (step != 2'sd0)) begin
            count_nxt = count_r + {{(`CNT_W-2){step[1]}}, step};
        end else if (reload_pend_r && i_reload_enable && !is_period) begin
            count_nxt = i_reload_value;
        end else if (is_period && period_open_r && src_edge) begin
            count_nxt = count_r + 1'b1;
        end
    end

    // Arm control, counting, index reload and period measurement.
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            arm_r <= 1'b0;
            edges_ok_r <= 1'b0;
            count_r <= {`CNT_W{1'b0}};
            reload_pend_r <= 1'b0;
            period_open_r <= 1'b0;
            o_period <= {`CNT_W{1'b0}};
            o_period_valid <= 1'b0;
        end else begin
            o_period_valid <= 1'b0;
            if (i_disarm) begin
                arm_r <= 1'b0;
                edges_ok_r <= 1'b0;
                reload_pend_r <= 1'b0;
                period_open_r <= 1'b0;
            end else if (!arm_r) begin
                if (i_arm) begin
                    // Counting begins at the arm event from zero.
                    arm_r <= 1'b1;
                    count_r <= {`CNT_W{1'b0}};
                end
            end else begin
                edges_ok_r <= 1'b1;
                // Reload stays armed; normal decoding continues after it.
                reload_pend_r <= edges_ok_r && phase_true && z_now;
                count_r <= count_nxt;
                if (is_period && gate_edge) begin
                    if (period_open_r) begin
                        // Close one interval and open the next at once.
                        o_period <= count_r;
                        o_period_valid <= 1'b1;
                    end
                    period_open_r <= 1'b1;
                    count_r <= {`CNT_W{1'b0}};
                end
            end
        end
    end

    // Sample clock on the Gate route captures the cumulative count.
    // A capture while the FIFO is full and a word already waits is dropped and flagged sticky.
    // Only one capture can wait in the strobe stage, so a second edge
    // while the first still waits is the overrun case; the FIFO itself
    // never sees a partly written word.
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            fifo_din_r <= {`CNT_W{1'b0}};
            fifo_push_r <= 1'b0;
            o_overrun <= 1'b0;
        end else begin
            if (fifo_push_r && fifo_in_ready) begin
                fifo_push_r <= 1'b0;
            end
            if (i_arm && !arm_r) begin
                o_overrun <= 1'b0;
            end
            if (arm_r && !is_period && i_sample_enable && gate_edge) begin
                if (fifo_push_r && !fifo_in_ready) begin
                    o_overrun <= 1'b1;
                end else begin
                    // Count is only read, never cleared, by sampling.
                    fifo_din_r <= count_r;
                    fifo_push_r <= 1'b1;
                end
            end
        end
    end

    sample_fifo #(
        .WIDTH(`CNT_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_in_data(fifo_din_r),
        .i_in_valid(fifo_push_r),
        .o_in_ready(fifo_in_ready),
        .o_out_data(fifo_dout),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(dma_pop)
    );

    // DMA output register stage; refills when empty or taken.
    assign dma_pop = fifo_out_valid && (!o_dma_valid || i_dma_ready);
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_dma_data <= {`CNT_W{1'b0}};
            o_dma_valid <= 1'b0;
        end else begin
            if (dma_pop) begin
                o_dma_data <= fifo_dout;
                o_dma_valid <= 1'b1;
            end else if (i_dma_ready) begin
                o_dma_valid <= 1'b0;
            end
        end
    end

    // Registered copies of state and the on-demand read answer.
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_armed <= 1'b0;
            o_count <= {`CNT_W{1'b0}};
            o_read_valid <= 1'b0;
            o_read_data <= {`CNT_W{1'b0}};
        end else begin
            o_armed <= arm_r;
            o_count <= count_r;
            o_read_valid <= i_read_req;
            if (i_read_req) begin
                o_read_data <= count_r;
            end
        end
    end
endmodule

// ### hdl/sample_fifo.v
`timescale 1ns/1ps
// Small flip-flop FIFO between the capture logic and the DMA drain.
module sample_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire i_clk_sys,
    input wire i_reset,
    input wire [WIDTH-1:0] i_in_data,
    input wire i_in_valid,
    output wire o_in_ready,
    output wire [WIDTH-1:0] o_out_data,
    output wire o_out_valid,
    input wire i_out_ready
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // Storage words.
    reg [AW-1:0] wr_ptr_r; // Next slot to write.
    reg [AW-1:0] rd_ptr_r; // Oldest slot.
    reg [AW:0] level_r; // Words held; one bit wider so full is exact.
    wire push;
    wire pop;

    assign o_in_ready = (level_r != DEPTH[AW:0]);
    assign o_out_valid = (level_r != {(AW+1){1'b0}});
    assign o_out_data = mem_r[rd_ptr_r];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointers and level move together; push and pop may share a cycle.
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            level_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                level_r <= level_r + 1'b1;
            end else if (pop && !push) begin
                level_r <= level_r - 1'b1;
            end
        end
    end

    // Data storage needs no reset; level guards what is read.
    always @(posedge i_clk_sys) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end
endmodule

// ### shared/ctr_pos_regs.vh
`ifndef CTR_POS_REGS_VH
`define CTR_POS_REGS_VH
`define CNT_W 32
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define MODE_W 3
`define MODE_PERIOD 3'h0
`define MODE_SINGLE_EDGE_QUADRATURE 3'h1
`define MODE_DOUBLE_EDGE_QUADRATURE 3'h2
`define MODE_QUADRUPLE_EDGE_QUADRATURE 3'h3
`define MODE_TWO_PULSE 3'h4
`define PHASE_A_BIT 1
`define PHASE_B_BIT 0
`endif

// ### verif/counter_position_period_measure_tb.sv
`timescale 1ns/1ps
`include "ctr_pos_regs.vh"
// Self-checking bench; the encoder model drives A, B and index.
module counter_position_period_measure_tb;
    reg i_clk_sys, i_reset, i_arm, i_disarm, i_gate_falling, i_source_falling;
    reg i_reload_enable, i_sample_enable, i_gate, i_source, i_read_req, i_dma_ready;
    reg [`MODE_W-1:0] i_mode;
    reg [1:0] i_reload_phase;
    reg [`CNT_W-1:0] i_reload_value;
    wire i_enc_a, i_enc_b, i_enc_index, o_armed, o_read_valid, o_period_valid;
    wire o_dma_valid, o_overrun;
    wire [`CNT_W-1:0] o_count, o_read_data, o_period, o_dma_data;
    integer failures, compares;
    counter_position_period_measure u_dut (.*);
    quad_encoder_model u_enc (.i_clk_sys(i_clk_sys), .o_a(i_enc_a), .o_b(i_enc_b),
        .o_z(i_enc_index));
    task check(input string nm, input [`CNT_W-1:0] seen, input [`CNT_W-1:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task stop_test;
        begin
            if (failures == 0 && compares > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // Disarm then arm; disarm first so the arm is always taken from idle.
    task rearm(input [`MODE_W-1:0] m);
        begin
            @(posedge i_clk_sys);
            i_disarm <= 1'b1;
            i_mode <= m;
            @(posedge i_clk_sys);
            i_disarm <= 1'b0;
            i_arm <= 1'b1;
            @(posedge i_clk_sys);
            i_arm <= 1'b0;
            tick(2);
        end
    endtask
    task steps(input reg dir, input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                u_enc.step(dir, 6);
            end
            tick(6);
        end
    endtask
    // Toggle Gate (g high) or Source out and back, four cycles per level.
    task strobe(input reg g);
        begin
            {i_gate, i_source} <= {i_gate, i_source} ^ {g, ~g};
            tick(4);
            {i_gate, i_source} <= {i_gate, i_source} ^ {g, ~g};
            tick(4);
        end
    endtask
    task pop(input [`CNT_W-1:0] exp);
        integer n;
        begin
            n = 0;
            @(posedge i_clk_sys);
            while (o_dma_valid !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge i_clk_sys);
            end
            check("dma data", o_dma_data, exp);
        end
    endtask
    task t_unarmed;
        begin
            i_mode <= `MODE_QUADRUPLE_EDGE_QUADRATURE;
            steps(1'b1, 4);
            check("idle count", o_count, 0);
        end
    endtask
    // Two cycles forward, one back, in each resolution: 1, 2 and 4 per cycle.
    task t_quad;
        integer k;
        begin
            for (k = 1; k < 4; k = k + 1) begin
                rearm(k[2:0]);
                steps(1'b1, 8);
                check("quad fwd", o_count, 2 << (k - 1));
                steps(1'b0, 4);
                check("quad back", o_count, 1 << (k - 1));
            end
        end
    endtask
    // Going below zero shows the signed wrap.
    task t_two_pulse;
        begin
            rearm(`MODE_TWO_PULSE);
            repeat (3) u_enc.pulse(1'b1);
            u_enc.pulse(1'b0);
            check("two pulse", o_count, 2);
            repeat (3) u_enc.pulse(1'b0);
            check("two pulse wrap", o_count, 32'hffffffff);
        end
    endtask
    // The step into the reload phase lands first, so only the reload value remains.
    // The index stays high while the encoder leaves the phase; that step must still count.
    task t_index;
        begin
            i_reload_phase <= 2'h0;
            i_reload_value <= 32'h64;
            i_reload_enable <= 1'b1;
            rearm(`MODE_QUADRUPLE_EDGE_QUADRATURE);
            steps(1'b1, 3);
            u_enc.set_z(1'b1);
            steps(1'b1, 1);
            check("reload", o_count, 32'h64);
            steps(1'b1, 1);
            check("after reload", o_count, 32'h65);
            u_enc.set_z(1'b0);
            i_reload_enable <= 1'b0;
        end
    endtask
    // Falling-edge samples held back, then drained; a stalled drain overruns.
    task t_sample;
        begin
            {i_gate_falling, i_gate, i_sample_enable, i_dma_ready} <= 4'he;
            rearm(`MODE_SINGLE_EDGE_QUADRATURE);
            repeat (2) begin
                steps(1'b1, 4);
                strobe(1'b1);
            end
            i_read_req <= 1'b1;
            tick(1);
            i_read_req <= 1'b0;
            @(negedge i_clk_sys);
            check("read valid", o_read_valid, 1);
            check("read data", o_read_data, 2);
            @(posedge i_clk_sys);
            i_dma_ready <= 1'b1;
            pop(1);
            pop(2);
            i_dma_ready <= 1'b0;
            repeat (8) strobe(1'b1);
            check("overrun", o_overrun, 1);
            i_sample_enable <= 1'b0;
        end
    endtask
    // Five Source pulses between two active Gate edges, both polarities.
    task t_period;
        integer p;
        begin
            for (p = 0; p < 2; p = p + 1) begin
                {i_gate_falling, i_source_falling, i_gate, i_source} <= {4{p[0]}};
                rearm(`MODE_PERIOD);
                strobe(1'b1);
                repeat (5) strobe(1'b0);
                strobe(1'b1);
                check("period", o_period, 5);
            end
        end
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    // A hang is cut off well past the expected run of under a thousand cycles.
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        failures = failures + 1;
        stop_test;
    end
    initial begin
        failures = 0;
        compares = 0;
        i_reset = 1'b1;
        {i_arm, i_disarm, i_gate_falling, i_source_falling, i_reload_enable} = 5'h0;
        {i_sample_enable, i_gate, i_source, i_read_req, i_dma_ready} = 5'h0;
        i_mode = `MODE_PERIOD;
        i_reload_phase = 2'h0;
        i_reload_value = 32'h0;
        tick(4);
        i_reset <= 1'b0;
        t_unarmed;
        t_quad;
        t_two_pulse;
        t_index;
        t_sample;
        t_period;
        stop_test;
    end
endmodule

// ### verif/cpm_chk.sv
`timescale 1ns/1ps
`include "ctr_pos_regs.vh"
// Port checks on the position and period counter.
module cpm_chk (
    input wire i_clk_sys,
    input wire i_reset,
    input wire i_arm,
    input wire i_disarm,
    input wire i_read_req,
    input wire i_reload_enable,
    input wire i_dma_ready,
    input wire o_armed,
    input wire [`CNT_W-1:0] o_count,
    input wire o_read_valid,
    input wire o_period_valid,
    input wire [`CNT_W-1:0] o_dma_data,
    input wire o_dma_valid,
    input wire o_overrun
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    // The armed flag is a registered copy of the arm state, so it shows two edges later.
    a_arm_taken: assert property (i_arm && !i_disarm && !o_armed |-> ##2 o_armed)
        else $error("arm not taken");
    a_disarm_wins: assert property (i_disarm |-> ##2 !o_armed)
        else $error("disarm ignored");
    a_idle_frozen: assert property (!o_armed && !$past(o_armed) && !$past(o_armed, 2)
        |-> $stable(o_count)) else $error("count moved while idle");
    a_arm_clears: assert property ($rose(o_armed) |-> ##[1:2] o_count == 0)
        else $error("arm did not clear count");
    // Away from arm, reload and a period restart the count moves by at most one per cycle.
    a_count_step: assert property (o_armed && $past(o_armed) && $past(o_armed, 2)
        && !i_reload_enable && !$past(i_reload_enable) && !$past(i_reload_enable, 2)
        && !$past(o_period_valid)
        |-> o_count == $past(o_count) || o_count == $past(o_count) + 1
        || o_count == $past(o_count) - 1) else $error("count jumped");
    a_read_answer: assert property (i_read_req |=> o_read_valid)
        else $error("read not answered");
    a_read_quiet: assert property (!i_read_req |=> !o_read_valid)
        else $error("read valid without request");
    a_period_pulse: assert property (o_period_valid |=> !o_period_valid)
        else $error("period valid too long");
    a_dma_hold: assert property (o_dma_valid && !i_dma_ready && !i_arm && !i_disarm
        |=> o_dma_valid && $stable(o_dma_data)) else $error("dma word dropped");
    a_overrun_sticky: assert property (o_overrun && !i_arm |=> o_overrun)
        else $error("overrun lost");
endmodule
bind counter_position_period_measure cpm_chk u_chk (.*);

// ### verif/quad_encoder_model.sv
`timescale 1ns/1ps
// Encoder stand-in: A and B walk the Gray cycle, both low at rest.
module quad_encoder_model (
    input wire i_clk_sys,
    output reg o_a,
    output reg o_b,
    output reg o_z
);
    reg [1:0] ph_r = 2'h0; // Quadrature phase, zero with both channels low.
    initial begin
        o_a = 1'b0;
        o_b = 1'b0;
        o_z = 1'b0;
    end
    // Quarter cycle forward (A leads) or back (B leads), then rest for gap cycles.
    task step(input reg dir, input integer gap);
        begin
            ph_r = dir ? ph_r + 2'h1 : ph_r - 2'h1;
            @(posedge i_clk_sys);
            o_a <= ^ph_r;
            o_b <= ph_r[1];
            repeat (gap) @(posedge i_clk_sys);
        end
    endtask
    // Index level; raised from the phase before the one chosen for reload to the phase after it.
    task set_z(input reg z);
        begin
            @(posedge i_clk_sys);
            o_z <= z;
        end
    endtask
    // A lone pulse on A (ch high) or B, as a two-pulse encoder gives.
    task pulse(input reg ch);
        begin
            @(posedge i_clk_sys);
            {o_a, o_b} <= {ch, ~ch};
            repeat (6) @(posedge i_clk_sys);
            {o_a, o_b} <= 2'h0;
            repeat (6) @(posedge i_clk_sys);
        end
    endtask
endmodule
